//--- fsmc_defs.svh
// offsets, field positions, codes and reset values for the security and margin sequencer
`ifndef FSMC_DEFS_SVH
`define FSMC_DEFS_SVH

// register byte offsets on the avalon slave
`define FSMC_OFS_STATUS 6'h00
`define FSMC_OFS_PIDX 6'h04
`define FSMC_OFS_PDATA 6'h08
`define FSMC_OFS_SECURITY 6'h0c
`define FSMC_OFS_CONFIG 6'h10
`define FSMC_OFS_MARGIN 6'h14

// status register bit positions
`define FSMC_BIT_COMPLETE 7
`define FSMC_BIT_ACCESS_ERROR_FLAG 5
`define FSMC_BIT_PVIOL 4
`define FSMC_BIT_VHI 1
`define FSMC_BIT_VLO 0

// config register bit positions
`define FSMC_BIT_SPECIAL 0
`define FSMC_BIT_PF_PROT 1
`define FSMC_BIT_EE_PROT 2

// margin register field positions
`define FSMC_MARGIN_PF_LSB 0
`define FSMC_MARGIN_EE_LSB 8

// command codes
`define FSMC_CMD_UNSECURE 8'h0b
`define FSMC_CMD_KEY_VERIFY 8'h0c
`define FSMC_CMD_USER_MARGIN 8'h0d
`define FSMC_CMD_FIELD_MARGIN 8'h0e

// parameter index expected at launch
`define FSMC_IDX_UNSECURE 3'h0
`define FSMC_IDX_KEY 3'h4
`define FSMC_IDX_MARGIN 3'h2
`define FSMC_PARAM_LAST 3'h5

// security fields
`define FSMC_KEY_ENABLE_FIELD_ON 2'h2
`define FSMC_SEC_UNSECURE 2'h2
`define FSMC_SECURITY_RST 8'h03

// backdoor key location
`define FSMC_KEY_BASE 24'hff_fe00
`define FSMC_KEY_LAST 2'h3

// global address windows of the two arrays
`define FSMC_PF_LO 24'hfc_0000
`define FSMC_PF_HI 24'hff_ffff
`define FSMC_EE_LO 24'h10_0000
`define FSMC_EE_HI 24'h10_07ff

// margin level codes
`define FSMC_LVL_NORMAL 3'h0
`define FSMC_LVL_USER_M1 3'h1
`define FSMC_LVL_USER_M0 3'h2
`define FSMC_LVL_FIELD_M1 3'h3
`define FSMC_LVL_FIELD_M0 3'h4
`define FSMC_LVL_USER_MAX 16'h0002
`define FSMC_LVL_FIELD_MAX 16'h0004

`endif

//--- fsmc_pkg.sv
// types shared by the security and margin sequencer
package fsmc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_KEY   = 4'b0100,
    ST_FIN   = 4'b1000
  } fsmc_state_t;

  typedef struct packed {
    logic done;
    logic verify_err;
    logic noncorr_err;
  } fsmc_erase_res_t;

  typedef struct packed {
    logic [2:0] level;
    logic to_erased;
    logic to_programmed;
  } fsmc_margin_t;

endpackage

//--- fsmc_core.sv
// command sequencer for unsecure, backdoor key verify and margin level commands
// Summary of operation
// - command 0x0b erases both arrays, verifies, releases security only on pass
// - failed erase verify sets verify_status_hi, security stays as it was
// - unsecure: index not 000 gives access error, any protection gives violation
// - verify errors set verify_status_hi, uncorrectable ones verify_status_lo
// - host clears cmd_complete_flag to launch, device sets it when finished
// - command 0x0c checks key enable first, not 10 means access error, no compare
// - four key words compared with stored key from 0xff_fe00, full match unsecures
// - key mismatch keeps security, access error, later key verifies fail until reset
// - key verify needs index 100, never sets violation or verify status
// - command 0x0d takes address from words 0 and 1, level from word 2
// - eeprom target affects eeprom reads, pflash target affects both arrays
// - margin commands need index 010, no violation or verify status
// - margin level code outside the command's valid set gives access error
// - invalid 24-bit global address on margin commands gives access error
// - command not allowed in current mode gives access error
// - command 0x0e sets field margin, same layout, special modes only
// - level codes: 0 normal, 1 user m1, 2 user m0, 3 field m1, 4 field m0
// - margin-1 reads toward erased state, margin-0 toward programmed state
//
// The Avalon-MM slave port and the address map were decided locally.
`include "fsmc_defs.svh"

module fsmc_core import fsmc_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic erase_all_req,
  input wire fsmc_erase_res_t erase_res,
  output logic [23:0] key_rd_addr,
  input wire logic [15:0] key_rd_data,
  output fsmc_margin_t pf_margin,
  output fsmc_margin_t ee_margin
);

  fsmc_state_t state_ff;
  fsmc_state_t nxt_state;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [15:0] param_ff [0:5];
  logic [2:0] pidx_ff;
  logic [7:0] security_ff;
  logic [2:0] config_ff;
  logic complete_ff;
  logic acc_ff;
  logic pv_ff;
  logic vhi_ff;
  logic vlo_ff;
  logic lock_ff;
  logic mism_ff;
  logic [1:0] key_cnt_ff;
  logic erase_req_ff;
  logic [2:0] lvl_ff [0:1];
  fsmc_margin_t marg [0:1];

  // avalon slave: one wait state, then answer
  wire bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign avs_readdata = rdata_ff;
  wire busy = ~complete_ff;
  // writes while a command runs are dropped, so nothing shifts under the sequencer
  wire wr_en = avs_write & ack_ff & ~busy;
  wire sel_status = avs_address == `FSMC_OFS_STATUS;
  wire sel_pidx = avs_address == `FSMC_OFS_PIDX;
  wire sel_pdata = avs_address == `FSMC_OFS_PDATA;
  wire sel_sec = avs_address == `FSMC_OFS_SECURITY;
  wire sel_cfg = avs_address == `FSMC_OFS_CONFIG;
  wire sel_marg = avs_address == `FSMC_OFS_MARGIN;

  wire [7:0] status_rd = {complete_ff, 1'b0, acc_ff, pv_ff, 2'b00, vhi_ff, vlo_ff};
  wire [31:0] margin_rd = {21'h0, lvl_ff[1], 5'h0, lvl_ff[0]};
  // index 6 and 7 have no word behind them, read as zero instead of junk
  wire [15:0] pdata_rd = (pidx_ff <= `FSMC_PARAM_LAST) ? param_ff[pidx_ff] : 16'h0;
  wire [31:0] rd_mux = sel_status ? {24'h0, status_rd} :
                       sel_pidx   ? {29'h0, pidx_ff} :
                       sel_pdata  ? {16'h0, pdata_rd} :
                       sel_sec    ? {24'h0, security_ff} :
                       sel_cfg    ? {29'h0, config_ff} :
                       sel_marg   ? margin_rd : 32'h0;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // command word decode
  wire [7:0] cmd = param_ff[0][15:8];
  wire [23:0] gaddr = {param_ff[0][7:0], param_ff[1]};
  wire [15:0] lvl_word = param_ff[2];
  wire is_unsec = cmd == `FSMC_CMD_UNSECURE;
  wire is_key = cmd == `FSMC_CMD_KEY_VERIFY;
  wire is_user = cmd == `FSMC_CMD_USER_MARGIN;
  wire is_field = cmd == `FSMC_CMD_FIELD_MARGIN;
  wire is_margin = is_user | is_field;
  wire special = config_ff[`FSMC_BIT_SPECIAL];
  wire any_prot = config_ff[`FSMC_BIT_PF_PROT] | config_ff[`FSMC_BIT_EE_PROT];

  wire launch = wr_en & sel_status & avs_writedata[`FSMC_BIT_COMPLETE];

  wire idx_bad = is_unsec ? (pidx_ff != `FSMC_IDX_UNSECURE) :
                 is_key ? (pidx_ff != `FSMC_IDX_KEY) :
                 (pidx_ff != `FSMC_IDX_MARGIN);
  wire mode_bad = is_field & ~special;
  wire addr_pf = (gaddr >= `FSMC_PF_LO) & (gaddr <= `FSMC_PF_HI);
  wire addr_ee = (gaddr >= `FSMC_EE_LO) & (gaddr <= `FSMC_EE_HI);
  wire addr_bad = is_margin & ~(addr_pf | addr_ee);
  // field codes are refused by the user command
  wire [15:0] lvl_max = is_field ? `FSMC_LVL_FIELD_MAX : `FSMC_LVL_USER_MAX;
  wire lvl_bad = is_margin & (lvl_word > lvl_max);
  // enable and lockout are checked before any key word is read
  wire key_bad = is_key & ((security_ff[7:6] != `FSMC_KEY_ENABLE_FIELD_ON) | lock_ff);
  wire unknown = ~(is_unsec | is_key | is_margin);
  wire launch_acc = idx_bad | mode_bad | addr_bad | lvl_bad | key_bad | unknown;
  wire launch_pv = is_unsec & any_prot;
  wire launch_ok = ~launch_acc & ~launch_pv;

  // key compare walks parameter words 1..4 against the stored key
  wire key_last = key_cnt_ff == `FSMC_KEY_LAST;
  wire [2:0] key_pidx = {1'b0, key_cnt_ff} + 3'h1;
  assign key_rd_addr = `FSMC_KEY_BASE + {21'h0, key_cnt_ff, 1'b0};
  wire key_miss = key_rd_data != param_ff[key_pidx];
  wire in_key = state_ff == ST_KEY;
  wire in_erase = state_ff == ST_ERASE;
  wire key_done = in_key & key_last;
  wire key_fail = key_done & (mism_ff | key_miss);
  wire erase_done = in_erase & erase_res.done;
  wire erase_err = erase_res.verify_err | erase_res.noncorr_err;
  wire release_sec = (erase_done & ~erase_err) | (key_done & ~key_fail);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (launch) begin
          if (launch_ok & is_unsec) begin
            nxt_state = ST_ERASE;
          end else if (launch_ok & is_key) begin
            nxt_state = ST_KEY;
          end else begin
            nxt_state = ST_FIN;
          end
        end
      end
      ST_ERASE: begin
        if (erase_res.done) begin
          nxt_state = ST_FIN;
        end
      end
      ST_KEY: begin
        if (key_last) begin
          nxt_state = ST_FIN;
        end
      end
      ST_FIN: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      complete_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (launch) begin
        complete_ff <= 1'b0;
      end else if (state_ff == ST_FIN) begin
        complete_ff <= 1'b1;
      end
    end
  end

  // software side registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pidx_ff <= 3'h0;
      security_ff <= `FSMC_SECURITY_RST;
      config_ff <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        param_ff[i] <= 16'h0;
      end
    end else begin
      if (wr_en & sel_pidx) begin
        pidx_ff <= avs_writedata[2:0];
      end
      if (wr_en & sel_pdata & (pidx_ff <= `FSMC_PARAM_LAST)) begin
        param_ff[pidx_ff] <= avs_writedata[15:0];
      end
      if (wr_en & sel_cfg) begin
        config_ff <= avs_writedata[2:0];
      end
      if (release_sec) begin
        security_ff[1:0] <= `FSMC_SEC_UNSECURE;
      end else if (wr_en & sel_sec) begin
        security_ff <= avs_writedata[7:0];
      end
    end
  end

  // status flags: a hardware set wins over a same-cycle clear
  wire clr_acc = wr_en & sel_status & avs_writedata[`FSMC_BIT_ACCESS_ERROR_FLAG];
  wire clr_pv = wr_en & sel_status & avs_writedata[`FSMC_BIT_PVIOL];
  wire set_acc = (launch & launch_acc) | key_fail;
  wire set_pv = launch & launch_pv;
  wire set_vhi = erase_done & erase_err;
  wire set_vlo = erase_done & erase_res.noncorr_err;
  wire nxt_acc = set_acc | (acc_ff & ~clr_acc);
  wire nxt_pv = set_pv | (pv_ff & ~clr_pv);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      acc_ff <= 1'b0;
      pv_ff <= 1'b0;
      vhi_ff <= 1'b0;
      vlo_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      pv_ff <= nxt_pv;
      vhi_ff <= set_vhi | (vhi_ff & ~launch);
      vlo_ff <= set_vlo | (vlo_ff & ~launch);
      if (key_fail) begin
        lock_ff <= 1'b1;
      end
    end
  end

  // key walk and erase handshake
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      key_cnt_ff <= 2'h0;
      mism_ff <= 1'b0;
      erase_req_ff <= 1'b0;
    end else begin
      erase_req_ff <= launch & launch_ok & is_unsec;
      if (launch) begin
        key_cnt_ff <= 2'h0;
        mism_ff <= 1'b0;
      end else if (in_key) begin
        key_cnt_ff <= key_cnt_ff + 2'h1;
        mism_ff <= mism_ff | key_miss;
      end
    end
  end
  assign erase_all_req = erase_req_ff;

  // margin levels; a pflash target also drags the eeprom along
  wire apply_margin = launch & launch_ok & is_margin;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lvl_ff[0] <= `FSMC_LVL_NORMAL;
      lvl_ff[1] <= `FSMC_LVL_NORMAL;
    end else if (apply_margin) begin
      lvl_ff[1] <= lvl_word[2:0];
      if (addr_pf) begin
        lvl_ff[0] <= lvl_word[2:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_margin
      assign marg[g].level = lvl_ff[g];
      assign marg[g].to_erased = (lvl_ff[g] == `FSMC_LVL_USER_M1) |
                                 (lvl_ff[g] == `FSMC_LVL_FIELD_M1);
      assign marg[g].to_programmed = (lvl_ff[g] == `FSMC_LVL_USER_M0) |
                                     (lvl_ff[g] == `FSMC_LVL_FIELD_M0);
    end
  endgenerate
  assign pf_margin = marg[0];
  assign ee_margin = marg[1];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_unsec_launch;
    launch & is_unsec & launch_ok;
  endsequence
  sequence s_key_launch;
    launch & is_key;
  endsequence

  a_unsec_pass_release: assert property (
    s_unsec_launch ##1 erase_all_req ##[1:300] (erase_done & ~erase_err)
      |=> security_ff[1:0] == `FSMC_SEC_UNSECURE ##1 complete_ff)
    else $error("unsecure pass did not release security");

  a_unsec_fail_keep: assert property (
    erase_done & erase_res.verify_err |=> vhi_ff & $stable(security_ff) ##1 complete_ff)
    else $error("failed erase verify changed security or missed status");

  a_unsec_checks: assert property (
    launch & is_unsec & any_prot |=> pv_ff & (state_ff == ST_FIN) & ~erase_all_req)
    else $error("protected unsecure did not flag a violation");

  a_key_disabled: assert property (
    s_key_launch ##0 (security_ff[7:6] != `FSMC_KEY_ENABLE_FIELD_ON) |=> acc_ff & ~in_key ##1 complete_ff)
    else $error("disabled key verify was not refused");

  a_key_lockout: assert property (
    key_fail |=> lock_ff & acc_ff)
    else $error("key mismatch lockout not held");

  a_lock_refuse: assert property (
    s_key_launch ##0 lock_ff |=> acc_ff & ~in_key ##1 complete_ff)
    else $error("key verify ran during lockout");

  // pv_ff is compared with its value just after launch, a stale flag is the host's
  a_key_done: assert property (
    s_key_launch ##0 launch_ok |=> in_key [*4] ##2
      (complete_ff & ~vhi_ff & (pv_ff == $past(pv_ff, 5))))
    else $error("key verify did not finish in four compares");

  a_field_mode: assert property (
    launch & is_field & ~special |=> acc_ff & $stable(lvl_ff[0]) & $stable(lvl_ff[1]))
    else $error("field margin accepted outside special mode");

  a_user_level: assert property (
    launch & is_user & (lvl_word > `FSMC_LVL_USER_MAX) |=> acc_ff & $stable(lvl_ff[1]))
    else $error("user margin took an invalid level");

  a_margin_pf_both: assert property (
    apply_margin & addr_pf |=> ({13'h0, lvl_ff[0]} == $past(lvl_word)) &
      ({13'h0, lvl_ff[1]} == $past(lvl_word)) ##1 complete_ff)
    else $error("pflash margin not applied to both arrays");

  a_margin_ee_only: assert property (
    apply_margin & addr_ee |=> $stable(lvl_ff[0]))
    else $error("eeprom margin touched pflash reads");

  a_unsec_index: assert property (
    launch & is_unsec & (pidx_ff != `FSMC_IDX_UNSECURE) |=> acc_ff & ~in_erase & ~erase_all_req)
    else $error("unsecure ran with a wrong index");

  a_key_index: assert property (
    launch & is_key & (pidx_ff != `FSMC_IDX_KEY) |=> acc_ff & ~in_key)
    else $error("key verify ran with a wrong index");

  a_margin_index: assert property (
    launch & is_margin & (pidx_ff != `FSMC_IDX_MARGIN) |=>
      acc_ff & $stable(lvl_ff[0]) & $stable(lvl_ff[1]))
    else $error("margin command ran with a wrong index");

  a_margin_addr: assert property (
    launch & is_margin & ~(addr_pf | addr_ee) |=>
      acc_ff & $stable(lvl_ff[0]) & $stable(lvl_ff[1]))
    else $error("margin command took an invalid address");

  a_field_level: assert property (
    launch & is_field & special & (lvl_word > `FSMC_LVL_FIELD_MAX) |=> acc_ff & $stable(lvl_ff[1]))
    else $error("field margin took an invalid level");

  a_vlo_noncorr: assert property (
    erase_done & erase_res.noncorr_err |=> vlo_ff & vhi_ff)
    else $error("uncorrectable erase error not reported");

  a_key_pass: assert property (
    key_done & ~key_fail |=> security_ff[1:0] == `FSMC_SEC_UNSECURE)
    else $error("matching key did not release security");

  a_launch_busy: assert property (
    launch |=> ~complete_ff)
    else $error("launch did not clear the complete flag");

endmodule // fsmc_core

//--- fsmc_array_model.sv
// behavioural flash arrays: erase-all responder and stored backdoor key
module fsmc_array_model import fsmc_pkg::*; #(
  parameter logic [63:0] KEY = 64'h0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic erase_all_req,
  input wire logic [1:0] fail,
  input wire logic slow,
  output fsmc_erase_res_t erase_res,
  input wire logic [23:0] key_rd_addr,
  output logic [15:0] key_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_ff = '0;
  wire key_hit = (key_rd_addr[23:3] == 21'h1f_ffc0) && !key_rd_addr[0];
  // off-key addresses return ~KEY[15:0] xored with the address, so one whose low 16 bits are ffff reads back KEY[15:0]
  assign key_rd_data = key_hit ? KEY[16*key_rd_addr[2:1] +: 16] :
                       ~KEY[15:0] ^ key_rd_addr[15:0];
  // error bits only mean something with done; elsewhere verify_err follows bit 0 of cnt_ff, noncorr_err its inverse
  always @(posedge mclk) begin
    erase_res.done <= cnt_ff == 5'h1;
    erase_res.verify_err <= (cnt_ff == 5'h1) ? fail != 2'h0 : cnt_ff[0];
    erase_res.noncorr_err <= (cnt_ff == 5'h1) ? fail == 2'h2 : ~cnt_ff[0];
    if (!nrst) begin
      cnt_ff <= 5'h0;
    end else if (erase_all_req) begin
      cnt_ff <= slow ? 5'h14 : 5'h2;
    end else if (cnt_ff != 5'h0) begin
      cnt_ff <= cnt_ff - 5'h1;
    end
  end
endmodule // fsmc_array_model

//--- flash_security_margin_commands_bench.sv
// self-checking bench for the security and margin command sequencer
`include "fsmc_defs.svh"
module flash_security_margin_commands_bench import fsmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // key value is arbitrary
  localparam logic [63:0] KEY = 64'h4d2e_91a7_3c58_e60f;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, erase_all_req;
  logic [1:0] fail = 2'h0;
  logic slow = 1'b0;
  fsmc_erase_res_t erase_res;
  logic [23:0] key_rd_addr;
  logic [15:0] key_rd_data;
  fsmc_margin_t pf_margin, ee_margin;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_er = 0;

  always #25 mclk = ~mclk;

  fsmc_core uut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .erase_all_req(erase_all_req), .erase_res(erase_res),
    .key_rd_addr(key_rd_addr), .key_rd_data(key_rd_data), .pf_margin(pf_margin),
    .ee_margin(ee_margin));

  fsmc_array_model #(.KEY(KEY)) far (.mclk(mclk), .nrst(nrst), .erase_all_req(erase_all_req),
    .fail(fail), .slow(slow), .erase_res(erase_res), .key_rd_addr(key_rd_addr),
    .key_rd_data(key_rd_data));

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (erase_all_req === 1'b1) begin
      n_er <= n_er + 1;
    end
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; read data taken there
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // load words 0..4, set launch index, launch with stale flags cleared, poll for completion
  task automatic run(input logic [79:0] w, input logic [2:0] ix, input logic [31:0] e);
    for (int i = 0; i < 5; i++) begin
      wr(`FSMC_OFS_PIDX, 32'(i));
      wr(`FSMC_OFS_PDATA, {16'h0, w[16*i +: 16]});
    end
    wr(`FSMC_OFS_PIDX, {29'h0, ix});
    wr(`FSMC_OFS_STATUS, 32'hb0);
    q = 32'h0;
    // only reads until complete returns, never a write while busy
    for (int k = 0; k < 60 && q[7] !== 1'b1; k++) rd(`FSMC_OFS_STATUS);
    chk("status", e, q);
  endtask

  task automatic sec(input logic [31:0] e);
    rd(`FSMC_OFS_SECURITY);
    chk("security", e, q);
  endtask

  task automatic rst;
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
  endtask

  initial begin
    rst();
    rd(6'h00);
    chk("status reset", 32'h80, q);
    sec(32'h03);
    wr(6'h18, 32'hffff_ffff);
    rd(6'h18);
    chk("unmapped", 32'h0, q);
    // unsecure: wrong index, then each protection bit
    run({64'h0, 16'h0b00}, 3'h1, 32'ha0);
    for (int p = 2; p <= 4; p += 2) begin
      wr(`FSMC_OFS_CONFIG, 32'(p));
      run({64'h0, 16'h0b00}, 3'h0, 32'h90);
    end
    wr(`FSMC_OFS_CONFIG, 32'h0);
    fail <= 2'h1;
    run({64'h0, 16'h0b00}, 3'h0, 32'h82);
    sec(32'h03);
    fail <= 2'h2;
    run({64'h0, 16'h0b00}, 3'h0, 32'h83);
    fail <= 2'h0;
    slow <= 1'b1;
    run({64'h0, 16'h0b00}, 3'h0, 32'h80);
    sec(32'h02);
    chk("erase count", 32'h3, 32'(n_er));
    // key verify
    rst();
    run({KEY, 16'h0c00}, 3'h4, 32'ha0);
    sec(32'h03);
    wr(`FSMC_OFS_SECURITY, 32'h83);
    run({KEY, 16'h0c00}, 3'h3, 32'ha0);
    run({KEY ^ {16'h1, 48'h0}, 16'h0c00}, 3'h4, 32'ha0);
    sec(32'h83);
    run({KEY, 16'h0c00}, 3'h4, 32'ha0);
    rst();
    wr(`FSMC_OFS_SECURITY, 32'h83);
    run({KEY, 16'h0c00}, 3'h4, 32'h80);
    sec(32'h82);
    // user margin, pflash then eeprom target
    run({32'h0, 16'h0001, 16'h0000, 16'h0dfc}, 3'h2, 32'h80);
    chk("pf_margin", 32'h06, 32'(pf_margin));
    chk("ee_margin", 32'h06, 32'(ee_margin));
    run({32'h0, 16'h0002, 16'h0000, 16'h0d10}, 3'h2, 32'h80);
    rd(`FSMC_OFS_MARGIN);
    chk("margin", 32'h0201, q);
    run({32'h0, 16'h0003, 16'h0000, 16'h0dfc}, 3'h2, 32'ha0);
    run({32'h0, 16'h0001, 16'h0000, 16'h0dfc}, 3'h1, 32'ha0);
    run({32'h0, 16'h0001, 16'h0800, 16'h0d10}, 3'h2, 32'ha0);
    run({32'h0, 16'h0003, 16'h0000, 16'h0efc}, 3'h2, 32'ha0);
    rd(`FSMC_OFS_MARGIN);
    chk("margin kept", 32'h0201, q);
    // field margin in special mode, every level code
    wr(`FSMC_OFS_CONFIG, 32'h1);
    for (int l = 0; l < 5; l++) begin
      run({32'h0, 16'(l), 16'hfff0, 16'h0eff}, 3'h2, 32'h80);
      chk("pf_margin", {27'h0, 3'(l), l == 1 || l == 3, l == 2 || l == 4},
        32'(pf_margin));
      chk("ee_margin", {29'h0, 3'(l)}, 32'(ee_margin.level));
    end
    run({32'h0, 16'h0005, 16'h0000, 16'h0efc}, 3'h2, 32'ha0);
    test_done();
  end
endmodule // flash_security_margin_commands_bench
